/* core/cpu_ack_defs.svh */
/*
  Constants of the per-processor acknowledge and priority-drop block:
  register offsets, field positions, reset values and special identifiers.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef CPU_ACK_DEFS_SVH
`define CPU_ACK_DEFS_SVH

// Register byte offsets on the plain register port
`define OFS_ACK_GROUP0        8'h00
`define OFS_ACK_GROUP1        8'h04
`define OFS_ACK_NONMASKABLE   8'h08
`define OFS_END_OF_IRQ_GROUP0 8'h0C
`define OFS_END_OF_IRQ_GROUP1 8'h10
`define OFS_TOP_PENDING_GROUP0 8'h14
`define OFS_TOP_PENDING_GROUP1 8'h18
`define OFS_RUNNING_PRIORITY  8'h1C
`define OFS_CONTROL           8'h20
`define OFS_DEACTIVATE        8'h24

// Control register fields
`define CTRL_GRP0_EN_BIT      0
`define CTRL_GRP1_EN_BIT      1
`define CTRL_SPLIT_BIT        2
`define CTRL_SPLIT_TOP_BIT    3
`define CTRL_NMI_EN_BIT       4
`define CTRL_PMASK_LSB        8
`define CTRL_PMASK_MSB        15
`define CTRL_RESET            32'h0000_0000

// Identifier space
`define ID_W                  24
`define ID_SPECIAL_SEC_G1     24'h0003FC
`define ID_SPECIAL_NS_G1      24'h0003FD
`define ID_SPURIOUS           24'h0003FF
`define ID_RESERVED_LO        24'h0003FC
`define ID_RESERVED_HI        24'h0003FF
`define ID_SGI_LIMIT          24'h000010
`define ID_LPI_BASE           24'h002000
`define ID_LIMIT              24'h010000

// Priorities, active stack and top exception level
`define PRIO_IDLE             8'hFF
`define STACK_DEPTH           8
`define TOP_EL                2'h3

`endif

/* core/cpu_ack_pkg.sv */
/*
  Types of the per-processor acknowledge and priority-drop block.
  Assumes cpu_ack_defs.svh is on the include path.
*/
`include "cpu_ack_defs.svh"

package cpu_ack_pkg;

  // Group of an interrupt as reported by the distribution logic
  typedef enum logic [1:0] {GRP0, GRP1_SEC, GRP1_NS} grp_t;

  // One acknowledged interrupt awaiting its priority drop
  typedef struct packed {
    logic [7:0]         prio;
    logic [`ID_W-1:0]   id;
    grp_t               grp;
    logic               locality_specific_interrupt;
  } act_entry_t;

  // Whole state of the block
  typedef struct packed {
    act_entry_t [`STACK_DEPTH-1:0] stack;
    logic [3:0]                    depth;
    logic [31:0]                   rdata;
    logic                          grp0_en;
    logic                          grp1_en;
    logic                          split_deactivate_mode;
    logic                          split_deactivate_mode_top_level;
    logic                          nonmaskable_enable;
    logic [7:0]                    prio_mask;
    logic                          ack_valid;
    logic [`ID_W-1:0]              ack_id;
    logic                          ack_set_active;
    logic                          ack_keep_pending;
    logic                          ack_local_only;
    logic                          deact_valid;
    logic [`ID_W-1:0]              deact_id;
  } state_t;

endpackage

/* core/cpu_interface_ack_and_priority_drop.sv */
/*
  Per-processor physical interrupt interface: acknowledge, running priority,
  priority drop in last-in-first-out order, and deactivation requests.
  Assumes the distribution logic presents the top pending interrupt on the
  hp_* inputs, synchronous to core_clk_in, and acts on the ack_* and deact_*
  pulses one cycle after the register access that caused them.
*/
`timescale 1ns/100ps
`include "cpu_ack_defs.svh"

// Functional notes
// - Acknowledge sets running priority to that interrupt; non-LOCALITY_SPECIFIC_INTERRUPT ones become active.
// - Priority drop restores the running priority held before that acknowledge.
// - Deactivation clears active state so a pending one re-signals; LPIs need none.
// - Deactivation either joins the priority drop or waits for a separate write.
// - Request the processor only if group enabled and priority beats mask and running.
// - Top pending query registers return the identifier without changing state.
// - Running priority register shows the top undropped active priority.
// - LOCALITY_SPECIFIC_INTERRUPT acknowledge clears pending in redistribution and keeps no active state.
// - Non-LOCALITY_SPECIFIC_INTERRUPT acknowledge gives active-and-pending if re-triggered, else active only.
// - After acknowledge, request stays only for a preempting interrupt, else drops.
// - Separate acknowledge registers for group 0, group 1 and non-maskable.
// - Acknowledge returns the identifier when signallable, else a special identifier.
// - Every acknowledged interrupt updates the active priority tracking.
// - Secure top-level read of group 0 acknowledge names the needed state transition.
// - Non-maskable enable clear: group 1 serves all, non-maskable register undefined.
// - Enable set: each register returns special when the top mismatches its kind.
// - SOFTWARE_GENERATED_INTERRUPT acknowledge clears pending for this processor only.
// - Valid end-of-interrupt write to the matching group register drops priority.
// - Reserved, unsupported, or mismatching end-of-interrupt writes are ignored.
// - Acknowledge state changes need only be visible after a barrier.
// - After a drop running priority is next undropped active, or idle 0xFF.
// - Split mode bit of current level: 0 drop and deactivate, 1 drop only.
module cpu_interface_ack_and_priority_drop
  import cpu_ack_pkg::*;
(
  input  wire logic             core_clk_in,
  input  wire logic             srst_in,
  input  wire logic [7:0]       addr_in,
  input  wire logic [31:0]      wdata_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  output logic      [31:0]      rdata_out,
  input  wire logic [1:0]       el_in,
  input  wire logic             nonsecure_state_bit_in,
  input  wire logic             hp_valid_in,
  input  wire logic [`ID_W-1:0] hp_id_in,
  input  wire logic [7:0]       hp_prio_in,
  input  wire grp_t             hp_grp_in,
  input  wire logic             hp_nmi_in,
  input  wire logic             hp_retrigger_in,
  output logic                  irq_req_out,
  output logic                  ack_valid_out,
  output logic      [`ID_W-1:0] ack_id_out,
  output logic                  ack_set_active_out,
  output logic                  ack_keep_pending_out,
  output logic                  ack_local_only_out,
  output logic                  deact_valid_out,
  output logic      [`ID_W-1:0] deact_id_out
);

  state_t           state;
  state_t           next_state;
  logic [2:0]       top_idx;
  act_entry_t       top;
  logic [7:0]       run_prio;
  logic             grp_en;
  logic             can_signal;
  logic             hp_lpi;
  logic             top_el;
  logic             sec_top_el;
  logic             split_now;
  logic             stack_full;
  logic [`ID_W-1:0] wr_id;
  logic             wr_id_ok;
  logic             eoi_wr;
  logic             eoi_valid;
  logic             ack_take;
  logic [`ID_W-1:0] ack_answer;
  logic [7:0]       below_prio;

  // Top of the active stack and the running priority derived from it
  assign top_idx  = state.depth[2:0] - 3'h1;
  assign top      = state.stack[top_idx];
  assign run_prio = (state.depth == 4'h0) ? `PRIO_IDLE : top.prio;

  // Priority that runs after a drop: the entry below the top, or idle
  assign below_prio = (state.depth < 4'h2) ? `PRIO_IDLE : state.stack[top_idx - 3'h1].prio;

  // Signalling decision toward the processor
  assign grp_en     = (hp_grp_in == GRP0) ? state.grp0_en : state.grp1_en;
  assign can_signal = hp_valid_in && grp_en && (hp_prio_in < state.prio_mask)
                      && (hp_prio_in < run_prio);
  assign irq_req_out = can_signal;
  // Identifiers from the LOCALITY_SPECIFIC_INTERRUPT base up carry no active state
  assign hp_lpi      = (hp_id_in >= `ID_LPI_BASE);

  // Exception level and mode selection
  assign top_el     = (el_in == `TOP_EL);
  assign sec_top_el = top_el && !nonsecure_state_bit_in;
  assign split_now  = top_el ? state.split_deactivate_mode_top_level
                             : state.split_deactivate_mode;
  assign stack_full = (state.depth == 4'(`STACK_DEPTH));

  // Identifier carried by a write and its validity
  assign wr_id    = wdata_in[`ID_W-1:0];
  assign wr_id_ok = !((wr_id >= `ID_RESERVED_LO) && (wr_id <= `ID_RESERVED_HI))
                    && (wr_id < `ID_LIMIT);
  assign eoi_wr   = wr_in && ((addr_in == `OFS_END_OF_IRQ_GROUP0) || (addr_in == `OFS_END_OF_IRQ_GROUP1));
  assign eoi_valid = eoi_wr && wr_id_ok && (state.depth != 4'h0) && (wr_id == top.id)
                     && ((addr_in == `OFS_END_OF_IRQ_GROUP0) == (top.grp == GRP0));

  // Acknowledge decision for the three acknowledge registers
  always_comb begin
    ack_take   = 1'b0;
    ack_answer = `ID_SPURIOUS;
    // A full stack refuses the acknowledge and answers spurious
    if (rd_in && can_signal && !stack_full) begin
      unique case (addr_in)
        `OFS_ACK_GROUP0: begin
          if (hp_grp_in == GRP0) begin
            ack_take   = 1'b1;
            ack_answer = hp_id_in;
          end else if (sec_top_el) begin
            ack_answer = (hp_grp_in == GRP1_SEC) ? `ID_SPECIAL_SEC_G1 : `ID_SPECIAL_NS_G1;
          end
        end
        `OFS_ACK_GROUP1: begin
          if (hp_grp_in != GRP0 && !(state.nonmaskable_enable && hp_nmi_in)) begin
            ack_take   = 1'b1;
            ack_answer = hp_id_in;
          end
        end
        `OFS_ACK_NONMASKABLE: begin
          if (state.nonmaskable_enable && hp_grp_in != GRP0 && hp_nmi_in) begin
            ack_take   = 1'b1;
            ack_answer = hp_id_in;
          end
        end
        default: begin
          ack_take   = 1'b0;
          ack_answer = `ID_SPURIOUS;
        end
      endcase
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    next_state                = state;
    next_state.ack_valid      = 1'b0;
    next_state.deact_valid    = 1'b0;
    // Register read data, one cycle after the read strobe
    if (rd_in) begin
      unique case (addr_in)
        `OFS_ACK_GROUP0, `OFS_ACK_GROUP1, `OFS_ACK_NONMASKABLE:
          next_state.rdata = 32'(ack_answer);
        `OFS_TOP_PENDING_GROUP0:
          next_state.rdata = 32'((hp_valid_in && hp_grp_in == GRP0) ? hp_id_in : `ID_SPURIOUS);
        `OFS_TOP_PENDING_GROUP1:
          next_state.rdata = 32'((hp_valid_in && hp_grp_in != GRP0) ? hp_id_in : `ID_SPURIOUS);
        `OFS_RUNNING_PRIORITY:
          next_state.rdata = {24'h000000, run_prio};
        `OFS_CONTROL: begin
          next_state.rdata = 32'h0000_0000;
          next_state.rdata[`CTRL_GRP0_EN_BIT]   = state.grp0_en;
          next_state.rdata[`CTRL_GRP1_EN_BIT]   = state.grp1_en;
          next_state.rdata[`CTRL_SPLIT_BIT]     = state.split_deactivate_mode;
          next_state.rdata[`CTRL_SPLIT_TOP_BIT] = state.split_deactivate_mode_top_level;
          next_state.rdata[`CTRL_NMI_EN_BIT]    = state.nonmaskable_enable;
          next_state.rdata[`CTRL_PMASK_MSB:`CTRL_PMASK_LSB] = state.prio_mask;
        end
        default:
          next_state.rdata = 32'h0000_0000;
      endcase
    end
    // Acknowledge: push onto the active stack and tell redistribution
    if (ack_take) begin
      next_state.stack[state.depth[2:0]] = '{prio: hp_prio_in, id: hp_id_in, grp: hp_grp_in, locality_specific_interrupt: hp_lpi};
      next_state.depth            = state.depth + 4'h1;
      next_state.ack_valid        = 1'b1;
      next_state.ack_id           = hp_id_in;
      next_state.ack_set_active   = !hp_lpi;
      next_state.ack_keep_pending = !hp_lpi && hp_retrigger_in;
      next_state.ack_local_only   = (hp_id_in < `ID_SGI_LIMIT);
    end
    // Priority drop pops the stack; joint deactivation when not split
    if (eoi_valid) begin
      next_state.depth = state.depth - 4'h1;
      if (!split_now && !top.locality_specific_interrupt) begin
        next_state.deact_valid = 1'b1;
        next_state.deact_id    = top.id;
      end
    end
    // Separate deactivation only in split mode, never for LPIs
    if (wr_in && addr_in == `OFS_DEACTIVATE && split_now && wr_id_ok && wr_id < `ID_LPI_BASE) begin
      next_state.deact_valid = 1'b1;
      next_state.deact_id    = wr_id;
    end
    // Control register write
    if (wr_in && addr_in == `OFS_CONTROL) begin
      next_state.grp0_en   = wdata_in[`CTRL_GRP0_EN_BIT];
      next_state.grp1_en   = wdata_in[`CTRL_GRP1_EN_BIT];
      next_state.split_deactivate_mode           = wdata_in[`CTRL_SPLIT_BIT];
      next_state.split_deactivate_mode_top_level = wdata_in[`CTRL_SPLIT_TOP_BIT];
      next_state.nonmaskable_enable              = wdata_in[`CTRL_NMI_EN_BIT];
      next_state.prio_mask = wdata_in[`CTRL_PMASK_MSB:`CTRL_PMASK_LSB];
    end
  end

  // State register; acknowledge effects are visible the next cycle, well before any barrier
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      // Groups off and mask zero keep the request low after reset
      state         <= '0;
      state.grp0_en <= 1'b0;
      state.grp1_en <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops
  assign rdata_out            = state.rdata;
  assign ack_valid_out        = state.ack_valid;
  assign ack_id_out           = state.ack_id;
  assign ack_set_active_out   = state.ack_set_active;
  assign ack_keep_pending_out = state.ack_keep_pending;
  assign ack_local_only_out   = state.ack_local_only;
  assign deact_valid_out      = state.deact_valid;
  assign deact_id_out         = state.deact_id;

  // Checks on the block's own behaviour
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  a_idle_running_prio: assert property (state.depth == 4'h0 |-> run_prio == 8'hFF)
    else $error("running priority not idle with empty stack");

  // Acknowledge raises the running priority
  a_ack_sets_prio: assert property (ack_take |=> run_prio == $past(hp_prio_in) && ack_valid_out)
    else $error("acknowledge did not set running priority");

  // Acknowledge pushes one entry
  a_ack_grows_stack: assert property (ack_take |=> state.depth == $past(state.depth) + 4'h1)
    else $error("acknowledge did not grow active stack");

  // Drop returns to the priority held before that acknowledge
  a_drop_restores_prio: assert property (eoi_valid |=> run_prio == $past(below_prio))
    else $error("priority drop did not restore earlier priority");

  // Valid end of interrupt pops one entry
  a_drop_shrinks_stack: assert property (eoi_valid |=> state.depth == $past(state.depth) - 4'h1)
    else $error("priority drop did not pop");

  // Reserved identifiers never drop
  a_reserved_eoi_ignored: assert property (eoi_wr && wr_id >= `ID_RESERVED_LO && wr_id <= `ID_RESERVED_HI
                                            |=> $stable(state.depth))
    else $error("reserved identifier caused priority drop");

  // Joint mode deactivates with the drop
  a_joint_deactivate: assert property (eoi_valid && !split_now && !top.locality_specific_interrupt |=> deact_valid_out
                                        && deact_id_out == $past(top.id))
    else $error("joint deactivation missing");

  // Split mode leaves it active
  a_split_no_deact: assert property (eoi_valid && split_now |=> !deact_valid_out)
    else $error("split mode deactivated on drop");

  // LPIs never become active
  a_lpi_not_active: assert property (ack_valid_out && ack_id_out >= `ID_LPI_BASE
                                      |-> !ack_set_active_out && !ack_keep_pending_out)
    else $error("LOCALITY_SPECIFIC_INTERRUPT given active state");

  // Request only above mask and running priority
  a_irq_gated_prio: assert property (irq_req_out |-> hp_prio_in < run_prio && hp_prio_in < state.prio_mask)
    else $error("request raised without sufficient priority");

  // Query reads have no side effect
  a_query_no_effect: assert property (rd_in && addr_in == `OFS_TOP_PENDING_GROUP1
                                       |=> $stable(state.depth) && !ack_valid_out)
    else $error("query read changed state");

  // Secure top level names the transition
  a_top_el_special: assert property (rd_in && addr_in == `OFS_ACK_GROUP0 && can_signal && sec_top_el && !stack_full
                                      && hp_grp_in == GRP1_NS |=> rdata_out == 32'h0000_03FD)
    else $error("missing state transition identifier");

  // Group 1 refuses a non-maskable top when enabled
  a_nmi_special: assert property (rd_in && addr_in == `OFS_ACK_GROUP1 && state.nonmaskable_enable && hp_nmi_in
                                   |=> rdata_out == 32'h0000_03FF && !ack_valid_out)
    else $error("group 1 acknowledged a non-maskable interrupt");

  // Acknowledge reports the taken identifier
  a_ack_id_out: assert property (ack_take
    |=> ack_id_out == $past(hp_id_in))
    else $error("acknowledge identifier wrong");

  // Only SGIs are flagged local
  a_local_only: assert property (ack_take
    |=> ack_local_only_out == ($past(hp_id_in) < `ID_SGI_LIMIT))
    else $error("local only flag wrong");

  // Re-triggered non-LOCALITY_SPECIFIC_INTERRUPT stays pending too
  a_keep_pending: assert property (ack_take && !hp_lpi && hp_retrigger_in
    |=> ack_keep_pending_out && ack_set_active_out)
    else $error("re-triggered interrupt lost pending");

  // Non-maskable register undefined when disabled
  a_nmi_off_undef: assert property (rd_in && addr_in == `OFS_ACK_NONMASKABLE
    && !state.nonmaskable_enable
    |=> rdata_out == 32'h0000_03FF && !ack_valid_out)
    else $error("disabled non-maskable register acknowledged");

  // Group 1 serves all group 1 when disabled
  a_grp1_serves_all: assert property (rd_in && addr_in == `OFS_ACK_GROUP1 && can_signal
    && !stack_full && hp_grp_in != GRP0 && !state.nonmaskable_enable
    |=> ack_valid_out && rdata_out[`ID_W-1:0] == $past(hp_id_in))
    else $error("group 1 did not acknowledge");

  // Nothing signallable answers spurious
  a_unsignalled_spurious: assert property (rd_in && !can_signal
    && (addr_in == `OFS_ACK_GROUP0 || addr_in == `OFS_ACK_GROUP1 || addr_in == `OFS_ACK_NONMASKABLE)
    |=> rdata_out == 32'h0000_03FF && !ack_valid_out)
    else $error("unsignallable interrupt acknowledged");

  // LPIs are never deactivated
  a_deact_not_lpi: assert property (deact_valid_out
    |-> deact_id_out < `ID_LPI_BASE)
    else $error("deactivation of an LOCALITY_SPECIFIC_INTERRUPT");

  // Stack never overflows
  a_stack_bounded: assert property (state.depth <= 4'(`STACK_DEPTH))
    else $error("active stack overflow");

  // Request needs its group enabled
  a_group_gate: assert property (irq_req_out
    |-> (hp_grp_in == GRP0 ? state.grp0_en : state.grp1_en))
    else $error("request from disabled group");

  // Group 1 register cannot drop a group 0 entry
  a_wrong_group_eoi: assert property (wr_in && addr_in == `OFS_END_OF_IRQ_GROUP1 && top.grp == GRP0
    |=> $stable(state.depth))
    else $error("wrong group end of interrupt dropped");

  // Split mode deactivates on the separate write
  a_split_deact_write: assert property (wr_in && addr_in == `OFS_DEACTIVATE && split_now
    && wr_id_ok && wr_id < `ID_LPI_BASE
    |=> deact_valid_out && deact_id_out == $past(wr_id))
    else $error("separate deactivation missing");

  // Running priority read shows the top entry
  a_rpr_read: assert property (rd_in && addr_in == `OFS_RUNNING_PRIORITY
    |=> rdata_out == {24'h000000, $past(run_prio)})
    else $error("running priority read wrong");

  // Priority at or below mask never requests
  a_mask_blocks: assert property (hp_prio_in >= state.prio_mask
    |-> !irq_req_out)
    else $error("request despite mask");

  // Main scenarios worth seeing
  c_nested_ack: cover property (ack_take ##[1:20] ack_take);
  c_lpi_ack: cover property (ack_take && hp_lpi);
  c_split_deact: cover property (eoi_valid && split_now ##[1:20] deact_valid_out);
  c_joint_drop: cover property (eoi_valid && !split_now);
  c_nmi_ack: cover property (ack_take && addr_in == `OFS_ACK_NONMASKABLE);

endmodule

/* sim/cpu_interface_ack_and_priority_drop_tb.sv */
/*
  Self-checking bench of the acknowledge and priority-drop block.
  Assumes the design files and dist_model are compiled first.
*/
`timescale 1ns/100ps
`include "cpu_ack_defs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module cpu_interface_ack_and_priority_drop_tb
  import cpu_ack_pkg::*;
;
  typedef struct packed {logic [23:0] id; logic [7:0] prio; grp_t grp; logic [7:0] ofs; logic [23:0] exp; logic ack;} row_t;
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, set = 1'b0, snmi = 1'b0, srt = 1'b0, ns = 1'b1;
  logic [7:0] addr = 8'h00, sprio = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] el = 2'h1;
  logic [23:0] sid = 24'h0, hid, ack_id, deact_id;
  grp_t sgrp = GRP0, hgrp;
  logic [7:0] hprio;
  logic hval, hnmi, hrt, irq, ack_v, ack_act, ack_kp, ack_loc, deact_v;
  int errors = 0, n_checks = 0, cyc = 0;
  // Ordinary cases: mask F0, both groups on, non-secure level 1
  row_t rows[9] = '{'{24'h20, 8'h40, GRP0, 8'h14, 24'h20, 1'b0}, '{24'h20, 8'h40, GRP0, 8'h18, 24'h3FF, 1'b0},
    '{24'h21, 8'h40, GRP1_NS, 8'h04, 24'h21, 1'b1}, '{24'h22, 8'h40, GRP0, 8'h04, 24'h3FF, 1'b0},
    '{24'h23, 8'h40, GRP1_SEC, 8'h00, 24'h3FF, 1'b0}, '{24'h24, 8'hF0, GRP0, 8'h00, 24'h3FF, 1'b0},
    '{24'h25, 8'h30, GRP0, 8'h00, 24'h25, 1'b1}, '{24'h26, 8'h40, GRP1_NS, 8'h1C, 24'hFF, 1'b0},
    '{24'h27, 8'h40, GRP0, 8'h40, 24'h0, 1'b0}};

  cpu_interface_ack_and_priority_drop u_cpu_interface_ack_and_priority_drop (.core_clk_in(clk), .srst_in(srst),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .el_in(el),
    .nonsecure_state_bit_in(ns), .hp_valid_in(hval), .hp_id_in(hid), .hp_prio_in(hprio), .hp_grp_in(hgrp),
    .hp_nmi_in(hnmi), .hp_retrigger_in(hrt), .irq_req_out(irq), .ack_valid_out(ack_v), .ack_id_out(ack_id),
    .ack_set_active_out(ack_act), .ack_keep_pending_out(ack_kp), .ack_local_only_out(ack_loc),
    .deact_valid_out(deact_v), .deact_id_out(deact_id));
  dist_model u_dist_model (.core_clk_in(clk), .srst_in(srst), .set_in(set), .set_id_in(sid), .set_prio_in(sprio),
    .set_grp_in(sgrp), .set_nmi_in(snmi), .set_retrig_in(srt), .ack_valid_in(ack_v), .ack_id_in(ack_id),
    .ack_keep_pending_in(ack_kp), .hp_valid_out(hval), .hp_id_out(hid), .hp_prio_out(hprio), .hp_grp_out(hgrp),
    .hp_nmi_out(hnmi), .hp_retrigger_out(hrt));

  // Clock and timeout
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Register bus cycles, one-cycle strobes, outputs taken in the answer cycle
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rp(input logic [7:0] e);
    rd_reg(`OFS_RUNNING_PRIORITY);
    `CHK("running prio", {24'h0, e}, d)
  endtask
  task automatic pend(input logic [23:0] i, input logic [7:0] p, input grp_t g, input logic n, input logic r);
    @(posedge clk);
    set <= 1'b1;
    sid <= i;
    sprio <= p;
    sgrp <= g;
    snmi <= n;
    srt <= r;
    @(posedge clk);
    set <= 1'b0;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rp(8'hFF);
    `CHK("irq idle", 1'b0, irq)
    wr_reg(`OFS_CONTROL, 32'h0000_F003);
    foreach (rows[i]) begin
      pend(rows[i].id, rows[i].prio, rows[i].grp, 1'b0, 1'b0);
      rd_reg(rows[i].ofs);
      `CHK("row read", {8'h0, rows[i].exp}, d)
      if (rows[i].ack) begin
        `CHK("ack pulse", 1'b1, ack_v)
        `CHK("irq after ack", 1'b0, irq)
        rp(rows[i].prio);
        wr_reg(rows[i].grp == GRP0 ? `OFS_END_OF_IRQ_GROUP0 : `OFS_END_OF_IRQ_GROUP1, {8'h0, rows[i].id});
        `CHK("joint deact", 1'b1, deact_v)
        rp(8'hFF);
      end
    end
    $display("table done");
    // Nesting, urgency order, invalid and wrong-group drops
    pend(24'h30, 8'h40, GRP0, 1'b0, 1'b0);
    rd_reg(`OFS_ACK_GROUP0);
    pend(24'h32, 8'h50, GRP1_NS, 1'b0, 1'b0);
    #1;
    `CHK("no preempt", 1'b0, irq)
    pend(24'h31, 8'h20, GRP1_NS, 1'b0, 1'b0);
    #1;
    `CHK("preempt", 1'b1, irq)
    rd_reg(`OFS_ACK_GROUP1);
    `CHK("nested id", 32'h31, d)
    wr_reg(`OFS_END_OF_IRQ_GROUP1, 32'h3FE);
    rp(8'h20);
    wr_reg(`OFS_END_OF_IRQ_GROUP0, 32'h31);
    rp(8'h20);
    wr_reg(`OFS_END_OF_IRQ_GROUP1, 32'h31);
    rp(8'h40);
    wr_reg(`OFS_END_OF_IRQ_GROUP0, 32'h30);
    rp(8'hFF);
    $display("nesting done");
    // Split mode with a re-triggered interrupt
    wr_reg(`OFS_CONTROL, 32'h0000_F007);
    pend(24'h40, 8'h40, GRP0, 1'b0, 1'b1);
    rd_reg(`OFS_ACK_GROUP0);
    `CHK("active", 1'b1, ack_act)
    `CHK("act and pend", 1'b1, ack_kp)
    `CHK("ack id", 24'h40, ack_id)
    wr_reg(`OFS_END_OF_IRQ_GROUP0, 32'h40);
    `CHK("no deact", 1'b0, deact_v)
    wr_reg(`OFS_DEACTIVATE, 32'h40);
    `CHK("deact", 1'b1, deact_v)
    `CHK("deact id", 24'h40, deact_id)
    wr_reg(`OFS_CONTROL, 32'h0000_F003);
    $display("split done");
    // Locality-specific and software-generated acknowledges
    pend(24'h2000, 8'h40, GRP1_NS, 1'b0, 1'b0);
    rd_reg(`OFS_ACK_GROUP1);
    `CHK("lpi no active", 1'b0, ack_act)
    wr_reg(`OFS_END_OF_IRQ_GROUP1, 32'h2000);
    rp(8'hFF);
    pend(24'h5, 8'h40, GRP1_NS, 1'b0, 1'b0);
    rd_reg(`OFS_ACK_GROUP1);
    `CHK("sgi local", 1'b1, ack_loc)
    wr_reg(`OFS_END_OF_IRQ_GROUP1, 32'h5);
    $display("lpi sgi done");
    // Top level secure, then non-maskable selection
    @(posedge clk);
    el <= 2'h3;
    ns <= 1'b0;
    pend(24'h50, 8'h40, GRP1_NS, 1'b0, 1'b0);
    rd_reg(`OFS_ACK_GROUP0);
    `CHK("to nonsecure", 32'h3FD, d)
    pend(24'h51, 8'h40, GRP1_SEC, 1'b0, 1'b0);
    rd_reg(`OFS_ACK_GROUP0);
    `CHK("to secure", 32'h3FC, d)
    wr_reg(`OFS_CONTROL, 32'h0000_F00B);
    pend(24'h52, 8'h40, GRP0, 1'b0, 1'b0);
    rd_reg(`OFS_ACK_GROUP0);
    `CHK("top ack", 32'h52, d)
    wr_reg(`OFS_END_OF_IRQ_GROUP0, 32'h52);
    `CHK("top split", 1'b0, deact_v)
    wr_reg(`OFS_DEACTIVATE, 32'h52);
    `CHK("top deact", 1'b1, deact_v)
    @(posedge clk);
    el <= 2'h1;
    ns <= 1'b1;
    pend(24'h60, 8'h40, GRP1_NS, 1'b1, 1'b0);
    rd_reg(`OFS_ACK_NONMASKABLE);
    `CHK("nmi off", 32'h3FF, d)
    wr_reg(`OFS_CONTROL, 32'h0000_F013);
    rd_reg(`OFS_ACK_GROUP1);
    `CHK("grp1 sees nmi", 32'h3FF, d)
    rd_reg(`OFS_ACK_NONMASKABLE);
    `CHK("nmi ack", 32'h60, d)
    $display("nmi done");
    // Reset in mid-run with an interrupt still active
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rp(8'hFF);
    rd_reg(`OFS_CONTROL);
    `CHK("ctrl reset", 32'h0, d)
    $display("reset done");
    wrap_up();
  end
endmodule

/* sim/dist_model.sv */
/*
  Distribution-side model: holds the one top pending interrupt offered to the block.
  Assumes the bench loads it and the block pulses ack one cycle after a read.
*/
`timescale 1ns/100ps
`include "cpu_ack_defs.svh"

module dist_model
  import cpu_ack_pkg::*;
(
  input  wire logic             core_clk_in,
  input  wire logic             srst_in,
  input  wire logic             set_in,
  input  wire logic [`ID_W-1:0] set_id_in,
  input  wire logic [7:0]       set_prio_in,
  input  wire grp_t             set_grp_in,
  input  wire logic             set_nmi_in,
  input  wire logic             set_retrig_in,
  input  wire logic             ack_valid_in,
  input  wire logic [`ID_W-1:0] ack_id_in,
  input  wire logic             ack_keep_pending_in,
  output logic                  hp_valid_out,
  output logic      [`ID_W-1:0] hp_id_out,
  output logic      [7:0]       hp_prio_out,
  output grp_t                  hp_grp_out,
  output logic                  hp_nmi_out,
  output logic                  hp_retrigger_out
);
  // Pending slot: loaded by the bench, cleared by an ack unless re-triggered
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      hp_valid_out <= 1'b0;
    end else if (set_in) begin
      hp_valid_out     <= 1'b1;
      hp_id_out        <= set_id_in;
      hp_prio_out      <= set_prio_in;
      hp_grp_out       <= set_grp_in;
      hp_nmi_out       <= set_nmi_in;
      hp_retrigger_out <= set_retrig_in;
    end else if (ack_valid_in && !ack_keep_pending_in && ack_id_in == hp_id_out) begin
      hp_valid_out <= 1'b0;
    end
  end
endmodule
